// File: scs_pkg.sv
/*
  servo compensation selector constants, encodings and carriers.
  assumes one 50 MHz control clock.
*/
`default_nettype none

package scs_pkg;

  // ==========================================================
  // function expansion setting bit positions
  localparam int FES_OBS_ENABLE_BIT = 1;
  localparam int FES_OBS_GAIN1_ONLY_BIT = 2;
  localparam int FES_INERTIA_SWITCH_BIT = 3;
  localparam int FES_W = 16;

  // ==========================================================
  // timing: third-gain effective time counts in 0.1 ms units
  localparam int CLK_PERIOD_NS = 20;
  localparam int EFFECTIVE_UNIT_NS = 100000;
  // least time per unit, rounded up to whole cycles
  localparam int EFFECTIVE_UNIT_CYCLES = (EFFECTIVE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // data widths and scaling
  localparam int GAIN_W = 16;
  localparam int TIME_W = 16;
  localparam int RATIO_W = 16;
  // third-gain ratio is a percentage of the first gain set
  localparam int RATIO_SCALE = 100;
  localparam int TORQUE_W = 16;

  // ==========================================================
  // reset values
  localparam logic [TORQUE_W-1:0] RST_OFFSET = 16'h0000;
  localparam logic [GAIN_W-1:0] RST_GAIN = 16'h0000;

  // ==========================================================
  // control mode, one-hot, same clock
  typedef enum logic [3:0] {
    MODE_POSITION = 4'b0001,
    MODE_SPEED = 4'b0010,
    MODE_TORQUE = 4'b0100,
    MODE_FULLY_CLOSED = 4'b1000
  } scs_mode_t;

  // active gain set
  typedef enum logic [2:0] {
    GAIN_FIRST = 3'b001,
    GAIN_SECOND = 3'b010,
    GAIN_THIRD = 3'b100
  } scs_gain_t;

  // servo state and excluding functions
  typedef struct packed {
    logic servo_on;
    logic autotune_en;
    logic adaptive_filter_en;
    logic inst_speed_obs_en;
  } scs_cond_t;

  // the two loop gains that the third set replaces
  typedef struct packed {
    logic [GAIN_W-1:0] pos_loop;
    logic [GAIN_W-1:0] speed_loop;
  } scs_gain_set_t;

endpackage

`default_nettype wire

// File: scs_region_timer.sv
/*
  interval timer for the third-gain region.
  assumes a one-cycle start pulse and UNIT_CYCLES of 2 or more.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_region_timer #(
  parameter int UNIT_CYCLES = 5000,
  parameter int LEN_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [LEN_W-1:0] length,
  // state
  output logic busy
);

  localparam int PRE_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);
  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

  logic [PRE_W-1:0] prescale; // cycles within the current unit
  logic [LEN_W-1:0] units; // units left in the region

  // ==========================================================
  // counting
  // a zero length never raises busy, so no region is inserted
  always_ff @(posedge mclk) begin
    if (rst || stop) begin
      busy <= 1'b0;
      prescale <= '0;
      units <= '0;
    end else if (start) begin
      busy <= (length != '0);
      prescale <= '0;
      units <= length;
    end else if (busy) begin
      if (prescale == PRE_LAST) begin
        prescale <= '0;
        units <= units - LEN_ONE;
        // last unit ends the region
        if (units == LEN_ONE) begin
          busy <= 1'b0;
        end
      end else begin
        prescale <= prescale + PRE_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// File: scs_selector.sv
/*
  servo compensation selector: observer gating, third gain set,
  torque offsets and inertia ratio selection.
  assumes one clock mclk; only the inertia select comes from a pin.
*/
// How it works
// RULE1: observer enabled only by expansion bit one
// RULE2: bit two limits observer to first gain
// RULE3: observer needs position/speed, servo on, no tuning
// RULE4: third gain needs servo on, position modes
// RULE5: third gain for set time, ratio of first
// RULE6: only position and speed gains change
// RULE7: gain-2 condition overrides third-gain region
// RULE8: second-to-third transition uses switching time
// RULE9: region also follows parameter-driven gain-1 return
// RULE10: unused third gain: time and ratio zero
// RULE11: unbalanced offset always added outside torque mode
// RULE12: friction offset follows position command direction
// RULE13: torque mode forces both offsets zero
// RULE14: speed mode servo off: unbalanced only
// RULE15: servo on holds offsets until first command
// RULE16: select input picks first or second inertia
// RULE17: inertia switching needs servo on, functions off
// RULE18: expansion bit three enables inertia switching
// RULE19: selections and offsets registered on control clock
`timescale 1ns/10ps
`default_nettype none

module scs_selector #(
  parameter int UNIT_CYCLES = scs_pkg::EFFECTIVE_UNIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration
  input wire logic [scs_pkg::FES_W-1:0] function_expansion_setting,
  input wire logic [scs_pkg::GAIN_W-1:0] disturbance_comp_gain,
  input wire logic [scs_pkg::GAIN_W-1:0] disturbance_filter_time,
  input wire logic [scs_pkg::TIME_W-1:0] third_gain_effective_time,
  input wire logic [scs_pkg::RATIO_W-1:0] third_gain_ratio,
  input wire logic [scs_pkg::TIME_W-1:0] position_gain_switch_time,
  input wire logic [scs_pkg::TORQUE_W-1:0] unbalanced_load_offset,
  input wire logic [scs_pkg::TORQUE_W-1:0] forward_friction_offset,
  input wire logic [scs_pkg::TORQUE_W-1:0] reverse_friction_offset,
  input wire logic [scs_pkg::GAIN_W-1:0] inertia_ratio_first,
  input wire logic [scs_pkg::GAIN_W-1:0] inertia_ratio_second,
  input wire scs_pkg::scs_gain_set_t gain_first,
  input wire scs_pkg::scs_gain_set_t gain_second,
  // drive state
  input wire scs_pkg::scs_mode_t control_mode,
  input wire scs_pkg::scs_cond_t drive_cond,
  input wire logic gain2_condition,
  input wire logic pos_cmd_forward,
  input wire logic pos_cmd_reverse,
  input wire logic inertia_select_input,
  // torque path
  input wire logic [scs_pkg::TORQUE_W-1:0] torque_cmd_in,
  output logic [scs_pkg::TORQUE_W-1:0] torque_cmd_out,
  // gain selection
  output scs_pkg::scs_gain_t gain_state,
  output scs_pkg::scs_gain_set_t loop_gain,
  output logic filters_use_second,
  output logic [scs_pkg::TIME_W-1:0] gain_ramp_time,
  // observer and inertia
  output logic observer_active,
  output logic [scs_pkg::GAIN_W-1:0] observer_gain,
  output logic [scs_pkg::GAIN_W-1:0] observer_filter,
  output logic [scs_pkg::GAIN_W-1:0] inertia_ratio
);

  // ==========================================================
  // declarations
  scs_pkg::scs_gain_t next_gain_state; // gain set for the next sample
  logic pos_modes; // position or fully-closed control
  logic third_allowed; // third-gain switching may run
  logic timer_start; // enter the third-gain region
  logic timer_stop; // leave the region early
  logic region_busy; // effective time still running
  logic isel_meta; // sync stage one
  logic isel_sync; // inertia select in the clock domain
  logic servo_prev; // servo on one sample ago
  logic offset_hold; // offsets frozen until first position command
  logic [scs_pkg::TORQUE_W-1:0] unbal_offset; // applied unbalanced offset
  logic [scs_pkg::TORQUE_W-1:0] fric_offset; // applied friction offset
  logic [scs_pkg::GAIN_W+scs_pkg::RATIO_W-1:0] prod_pos; // first pos gain times ratio
  logic [scs_pkg::GAIN_W+scs_pkg::RATIO_W-1:0] prod_spd; // first speed gain times ratio
  scs_pkg::scs_gain_set_t gain_third; // derived third gain set
  logic obs_next; // observer condition for the next sample
  logic [scs_pkg::TORQUE_W+1:0] torque_sum; // widened sum before clamping

  localparam logic [scs_pkg::GAIN_W+scs_pkg::RATIO_W-1:0] RATIO_DIV =
    (scs_pkg::GAIN_W + scs_pkg::RATIO_W)'(scs_pkg::RATIO_SCALE);
  localparam logic [scs_pkg::GAIN_W+scs_pkg::RATIO_W-1:0] GAIN_MAX =
    (scs_pkg::GAIN_W + scs_pkg::RATIO_W)'({scs_pkg::GAIN_W{1'b1}});

  // ==========================================================
  // inertia select synchroniser
  // the pin is asynchronous; two stages before any logic looks at it
  always_ff @(posedge mclk) begin
    if (rst) begin
      isel_meta <= 1'b0;
      isel_sync <= 1'b0;
    end else begin
      isel_meta <= inertia_select_input;
      isel_sync <= isel_meta;
    end
  end

  // ==========================================================
  // gain set sequencing
  assign pos_modes = (control_mode == scs_pkg::MODE_POSITION) ||
                     (control_mode == scs_pkg::MODE_FULLY_CLOSED);
  assign third_allowed = drive_cond.servo_on && pos_modes; // RULE4

  // next gain set
  always_comb begin
    next_gain_state = gain_state;
    timer_start = 1'b0;
    timer_stop = 1'b0;
    case (gain_state)
      scs_pkg::GAIN_FIRST: begin
        if (gain2_condition) begin
          next_gain_state = scs_pkg::GAIN_SECOND;
        end
      end
      scs_pkg::GAIN_SECOND: begin
        // the condition may drop by a parameter change too; same path
        if (!gain2_condition) begin // RULE9
          if (third_allowed && (third_gain_effective_time != '0)) begin // RULE5
            next_gain_state = scs_pkg::GAIN_THIRD;
            timer_start = 1'b1;
          end else begin
            next_gain_state = scs_pkg::GAIN_FIRST;
          end
        end
      end
      scs_pkg::GAIN_THIRD: begin
        if (gain2_condition) begin // RULE7
          next_gain_state = scs_pkg::GAIN_SECOND;
          timer_stop = 1'b1;
        end else if (!third_allowed) begin // RULE4
          next_gain_state = scs_pkg::GAIN_FIRST;
          timer_stop = 1'b1;
        end else if (!region_busy) begin // RULE5
          next_gain_state = scs_pkg::GAIN_FIRST;
        end
      end
      default: begin
        // an illegal code falls back to the safe first set
        next_gain_state = scs_pkg::GAIN_FIRST;
        timer_stop = 1'b1;
      end
    endcase
  end

  // gain state register, one change per sample
  always_ff @(posedge mclk) begin
    if (rst) begin
      gain_state <= scs_pkg::GAIN_FIRST;
    end else begin
      gain_state <= next_gain_state; // RULE19
    end
  end

  // effective-time counter for the third-gain region
  scs_region_timer #(
    .UNIT_CYCLES(UNIT_CYCLES),
    .LEN_W(scs_pkg::TIME_W)
  ) u_region_timer (
    .mclk(mclk),
    .rst(rst),
    .start(timer_start),
    .stop(timer_stop),
    .length(third_gain_effective_time),
    .busy(region_busy)
  );

  // ==========================================================
  // third gain values: percentage of the first set, saturated
  // a zero ratio gives zero loop gains, so an unused third set must
  // also carry a zero effective time to keep the region out
  assign prod_pos = gain_first.pos_loop * third_gain_ratio; // RULE5
  assign prod_spd = gain_first.speed_loop * third_gain_ratio;

  always_comb begin
    gain_third.pos_loop = scs_pkg::GAIN_W'(prod_pos / RATIO_DIV);
    gain_third.speed_loop = scs_pkg::GAIN_W'(prod_spd / RATIO_DIV);
    if ((prod_pos / RATIO_DIV) > GAIN_MAX) begin
      gain_third.pos_loop = {scs_pkg::GAIN_W{1'b1}};
    end
    if ((prod_spd / RATIO_DIV) > GAIN_MAX) begin
      gain_third.speed_loop = {scs_pkg::GAIN_W{1'b1}};
    end
  end

  // selected loop gains and filter set
  // filters and integral time follow gain 2 only in the second set
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop_gain <= {scs_pkg::RST_GAIN, scs_pkg::RST_GAIN};
      filters_use_second <= 1'b0;
    end else begin
      case (next_gain_state)
        scs_pkg::GAIN_SECOND: begin
          loop_gain <= gain_second;
          filters_use_second <= 1'b1;
        end
        scs_pkg::GAIN_THIRD: begin
          loop_gain <= gain_third; // RULE6
          filters_use_second <= 1'b0; // RULE6
        end
        default: begin
          loop_gain <= gain_first;
          filters_use_second <= 1'b0;
        end
      endcase
    end
  end

  // ramp time while moving from the second into the third set
  // other transitions report zero so the loop steps at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      gain_ramp_time <= '0;
    end else if (timer_start) begin
      gain_ramp_time <= position_gain_switch_time; // RULE8
    end else if (next_gain_state != scs_pkg::GAIN_THIRD) begin
      gain_ramp_time <= '0;
    end
  end

  // ==========================================================
  // disturbance observer gating
  always_comb begin
    obs_next = function_expansion_setting[scs_pkg::FES_OBS_ENABLE_BIT]; // RULE1
    if (function_expansion_setting[scs_pkg::FES_OBS_GAIN1_ONLY_BIT] &&
        (next_gain_state != scs_pkg::GAIN_FIRST)) begin // RULE2
      obs_next = 1'b0;
    end
    if (!drive_cond.servo_on || drive_cond.autotune_en ||
        drive_cond.inst_speed_obs_en) begin // RULE3
      obs_next = 1'b0;
    end
    if ((control_mode != scs_pkg::MODE_POSITION) &&
        (control_mode != scs_pkg::MODE_SPEED)) begin // RULE3
      obs_next = 1'b0;
    end
  end

  // observer enable and its parameters, zeroed when not acting
  always_ff @(posedge mclk) begin
    if (rst) begin
      observer_active <= 1'b0;
      observer_gain <= scs_pkg::RST_GAIN;
      observer_filter <= scs_pkg::RST_GAIN;
    end else begin
      observer_active <= obs_next;
      observer_gain <= obs_next ? disturbance_comp_gain : scs_pkg::RST_GAIN;
      observer_filter <= obs_next ? disturbance_filter_time : scs_pkg::RST_GAIN;
    end
  end

  // ==========================================================
  // inertia ratio selection
  // the ratio follows isel_sync one sample later, whether or not
  // the motor is moving; nothing waits for it to stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      inertia_ratio <= scs_pkg::RST_GAIN;
    end else if (function_expansion_setting[scs_pkg::FES_INERTIA_SWITCH_BIT] && // RULE18
                 drive_cond.servo_on && !drive_cond.autotune_en &&
                 !drive_cond.adaptive_filter_en && !drive_cond.inst_speed_obs_en &&
                 !obs_next && isel_sync) begin // RULE17
      inertia_ratio <= inertia_ratio_second; // RULE16
    end else begin
      inertia_ratio <= inertia_ratio_first; // RULE18
    end
  end

  // ==========================================================
  // torque offsets
  // servo edge tracker for the hold after servo on
  always_ff @(posedge mclk) begin
    if (rst) begin
      servo_prev <= 1'b0;
    end else begin
      servo_prev <= drive_cond.servo_on;
    end
  end

  // offset selection per mode and servo state
  always_ff @(posedge mclk) begin
    if (rst) begin
      unbal_offset <= scs_pkg::RST_OFFSET;
      fric_offset <= scs_pkg::RST_OFFSET;
      offset_hold <= 1'b0;
    end else begin
      case (control_mode)
        scs_pkg::MODE_TORQUE: begin
          unbal_offset <= scs_pkg::RST_OFFSET; // RULE13
          fric_offset <= scs_pkg::RST_OFFSET; // RULE13
          offset_hold <= 1'b0;
        end
        scs_pkg::MODE_SPEED: begin
          // friction compensation needs a position command direction
          unbal_offset <= unbalanced_load_offset; // RULE14
          fric_offset <= scs_pkg::RST_OFFSET; // RULE14
          offset_hold <= 1'b0;
        end
        scs_pkg::MODE_POSITION, scs_pkg::MODE_FULLY_CLOSED: begin
          if (drive_cond.servo_on && !servo_prev) begin
            offset_hold <= 1'b1; // RULE15
          end else if (!drive_cond.servo_on) begin
            unbal_offset <= unbalanced_load_offset; // RULE11
            offset_hold <= 1'b0;
          end else if (pos_cmd_forward || pos_cmd_reverse) begin
            offset_hold <= 1'b0; // RULE15
            unbal_offset <= unbalanced_load_offset; // RULE15
            // forward wins if both strobes arrive together
            fric_offset <= pos_cmd_forward ? forward_friction_offset :
                           reverse_friction_offset; // RULE12
          end else if (!offset_hold) begin
            unbal_offset <= unbalanced_load_offset; // RULE11
          end
        end
        default: begin
          unbal_offset <= scs_pkg::RST_OFFSET;
          fric_offset <= scs_pkg::RST_OFFSET;
          offset_hold <= 1'b0;
        end
      endcase
    end
  end

  // torque command sum, clamped to the signed range
  assign torque_sum = {{2{torque_cmd_in[scs_pkg::TORQUE_W-1]}}, torque_cmd_in} +
                      {{2{unbal_offset[scs_pkg::TORQUE_W-1]}}, unbal_offset} +
                      {{2{fric_offset[scs_pkg::TORQUE_W-1]}}, fric_offset};

  always_ff @(posedge mclk) begin
    if (rst) begin
      torque_cmd_out <= scs_pkg::RST_OFFSET;
    end else if (torque_sum[scs_pkg::TORQUE_W+1] &&
                 (torque_sum[scs_pkg::TORQUE_W:scs_pkg::TORQUE_W-1] != 2'b11)) begin
      torque_cmd_out <= {1'b1, {(scs_pkg::TORQUE_W-1){1'b0}}};
    end else if (!torque_sum[scs_pkg::TORQUE_W+1] &&
                 (torque_sum[scs_pkg::TORQUE_W:scs_pkg::TORQUE_W-1] != 2'b00)) begin
      torque_cmd_out <= {1'b0, {(scs_pkg::TORQUE_W-1){1'b1}}};
    end else begin
      torque_cmd_out <= torque_sum[scs_pkg::TORQUE_W-1:0]; // RULE19
    end
  end

endmodule

`default_nettype wire

// File: scs_selector_end.sv
/*
  empty unit: it holds no module.
*/
`default_nettype none
`default_nettype wire

// File: scs_selector_properties.sv
/*
  port checker bound to the selector top.
  assumes scs_pkg first and one clock mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_selector_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration and drive state
  input wire logic [15:0] function_expansion_setting,
  input wire logic [15:0] position_gain_switch_time,
  input wire logic [15:0] inertia_ratio_first,
  input wire scs_pkg::scs_mode_t control_mode,
  input wire scs_pkg::scs_cond_t drive_cond,
  input wire logic gain2_condition,
  input wire logic [15:0] torque_cmd_in,
  // watched outputs
  input wire logic [15:0] torque_cmd_out,
  input wire scs_pkg::scs_gain_t gain_state,
  input wire logic filters_use_second,
  input wire logic [15:0] gain_ramp_time,
  input wire logic observer_active,
  input wire logic [15:0] inertia_ratio
);
  // ==========================================================
  // one clock, paused in reset
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_obs_needs_enable: assert property (observer_active |-> $past(function_expansion_setting[1]))
    else $error("observer active while disabled");
  a_obs_gain_first: assert property (observer_active && $past(function_expansion_setting[2])
    |-> gain_state == scs_pkg::GAIN_FIRST) else $error("observer active outside gain one");
  a_obs_run_cond: assert property (observer_active |-> $past(drive_cond.servo_on
    && !drive_cond.autotune_en && !drive_cond.inst_speed_obs_en
    && control_mode inside {scs_pkg::MODE_POSITION, scs_pkg::MODE_SPEED}))
    else $error("observer active in wrong state");
  a_third_allowed: assert property (gain_state == scs_pkg::GAIN_THIRD |-> $past(
    drive_cond.servo_on && control_mode inside {scs_pkg::MODE_POSITION, scs_pkg::MODE_FULLY_CLOSED}))
    else $error("third gain outside position modes");
  a_third_filters: assert property (gain_state == scs_pkg::GAIN_THIRD |-> !filters_use_second)
    else $error("third region uses second filters");
  a_gain2_override: assert property (gain_state == scs_pkg::GAIN_THIRD && gain2_condition
    && drive_cond.servo_on && control_mode == scs_pkg::MODE_POSITION
    |=> gain_state == scs_pkg::GAIN_SECOND) else $error("gain two did not override");
  a_ramp_on_entry: assert property (gain_state == scs_pkg::GAIN_THIRD
    && $past(gain_state) == scs_pkg::GAIN_SECOND |-> gain_ramp_time == $past(position_gain_switch_time))
    else $error("ramp time missing on entry");
  // offsets lag mode one cycle, sum one more
  a_torque_no_offset: assert property (control_mode == scs_pkg::MODE_TORQUE
    |-> ##2 torque_cmd_out == $past(torque_cmd_in)) else $error("offset added in torque mode");
  a_inertia_default: assert property (!$past(rst) && !$past(function_expansion_setting[3])
    |-> inertia_ratio == $past(inertia_ratio_first)) else $error("second ratio while disabled");
  a_inertia_servo_off: assert property (!$past(rst) && !$past(drive_cond.servo_on)
    |-> inertia_ratio == $past(inertia_ratio_first)) else $error("second ratio with servo off");
endmodule

bind scs_selector scs_selector_properties chk_u (.mclk, .rst, .function_expansion_setting,
  .position_gain_switch_time, .inertia_ratio_first, .control_mode, .drive_cond, .gain2_condition,
  .torque_cmd_in, .torque_cmd_out, .gain_state, .filters_use_second, .gain_ramp_time,
  .observer_active, .inertia_ratio);

`default_nettype wire

// File: scs_cmd_source.sv
/*
  host command source: direction strobes after a delay.
  assumes one-cycle requests on mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_cmd_source (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // requests from the bench
  input wire logic req_fwd,
  input wire logic req_rev,
  input wire logic [3:0] delay,
  // direction strobes
  output logic pos_cmd_forward,
  output logic pos_cmd_reverse
);
  logic [3:0] cnt; // cycles left before the strobe
  logic dir; // high for a forward command

  // ==========================================================
  // one-cycle strobes expose a missed sample
  always_ff @(posedge mclk) begin
    pos_cmd_forward <= 1'b0;
    pos_cmd_reverse <= 1'b0;
    if (rst) begin
      cnt <= 4'h0;
    end else if (req_fwd || req_rev) begin
      cnt <= delay + 4'h1;
      dir <= req_fwd;
    end else if (cnt == 4'h1) begin
      pos_cmd_forward <= dir;
      pos_cmd_reverse <= !dir;
      cnt <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

`default_nettype wire

// File: scs_selector_tb_top.sv
/*
  self-checking bench for the selector.
  assumes all other files compiled.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_selector_tb_top;
  // row: inputs, expected observer and ratio
  typedef struct packed {
    logic [15:0] fes;
    logic [3:0] mode;
    logic [3:0] cond;
    logic pin;
    logic obs;
    logic sec;
  } scs_row_t;

  logic mclk, rst, gain2_condition, pos_cmd_forward, pos_cmd_reverse, inertia_select_input;
  logic req_fwd, req_rev, filters_use_second, observer_active;
  logic [3:0] dly;
  logic [15:0] function_expansion_setting, disturbance_comp_gain, disturbance_filter_time;
  logic [15:0] third_gain_effective_time, third_gain_ratio, position_gain_switch_time;
  logic [15:0] unbalanced_load_offset, forward_friction_offset, reverse_friction_offset;
  logic [15:0] inertia_ratio_first, inertia_ratio_second, torque_cmd_in, torque_cmd_out;
  logic [15:0] gain_ramp_time, observer_gain, observer_filter, inertia_ratio;
  scs_pkg::scs_gain_set_t gain_first, gain_second, loop_gain;
  scs_pkg::scs_mode_t control_mode;
  scs_pkg::scs_cond_t drive_cond;
  scs_pkg::scs_gain_t gain_state;
  int error_cnt = 0, samples_checked = 0, cycles = 0, n;
  scs_row_t rows[10] = '{
    '{16'h0002, 4'h1, 4'h8, 1'b0, 1'b1, 1'b0}, '{16'h0000, 4'h1, 4'h8, 1'b0, 1'b0, 1'b0},
    '{16'h0002, 4'h4, 4'h8, 1'b0, 1'b0, 1'b0}, '{16'h0002, 4'h2, 4'hC, 1'b0, 1'b0, 1'b0},
    '{16'h0002, 4'h2, 4'h9, 1'b0, 1'b0, 1'b0}, '{16'h0006, 4'h1, 4'h8, 1'b0, 1'b1, 1'b0},
    '{16'h0008, 4'h1, 4'h8, 1'b1, 1'b0, 1'b1}, '{16'h000A, 4'h1, 4'h8, 1'b1, 1'b1, 1'b0},
    '{16'h0008, 4'h1, 4'hA, 1'b1, 1'b0, 1'b0}, '{16'h0008, 4'h1, 4'h0, 1'b1, 1'b0, 1'b0}};

  // ==========================================================
  // design and command source
  scs_selector #(.UNIT_CYCLES(4)) dut_u (.mclk, .rst, .function_expansion_setting,
    .disturbance_comp_gain, .disturbance_filter_time, .third_gain_effective_time,
    .third_gain_ratio, .position_gain_switch_time, .unbalanced_load_offset,
    .forward_friction_offset, .reverse_friction_offset, .inertia_ratio_first,
    .inertia_ratio_second, .gain_first, .gain_second, .control_mode, .drive_cond,
    .gain2_condition, .pos_cmd_forward, .pos_cmd_reverse, .inertia_select_input,
    .torque_cmd_in, .torque_cmd_out, .gain_state, .loop_gain, .filters_use_second,
    .gain_ramp_time, .observer_active, .observer_gain, .observer_filter, .inertia_ratio);
  scs_cmd_source src_u (.mclk, .rst, .req_fwd, .req_rev, .delay(dly), .pos_cmd_forward,
    .pos_cmd_reverse);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic summarize;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1; gain2_condition = 1'b0; inertia_select_input = 1'b0;
    req_fwd = 1'b0; req_rev = 1'b0; dly = 4'h0; function_expansion_setting = 16'h0000;
    disturbance_comp_gain = 16'h0011; disturbance_filter_time = 16'h0044;
    third_gain_effective_time = 16'h0002; third_gain_ratio = 16'h0096;
    position_gain_switch_time = 16'h0033; unbalanced_load_offset = 16'h0010;
    forward_friction_offset = 16'h0005; reverse_friction_offset = 16'h0003;
    inertia_ratio_first = 16'h0033; inertia_ratio_second = 16'h0022; torque_cmd_in = 16'h0100;
    gain_first = 32'h0064_00C8; gain_second = 32'h0200_0300;
    control_mode = scs_pkg::MODE_POSITION; drive_cond = 4'h8;
    cyc(10);
    rst = 1'b0;
    chk(gain_state, scs_pkg::GAIN_FIRST);
    chk(torque_cmd_out, 16'h0000);
    foreach (rows[i]) begin
      function_expansion_setting = rows[i].fes;
      control_mode = scs_pkg::scs_mode_t'(rows[i].mode);
      drive_cond = rows[i].cond;
      inertia_select_input = rows[i].pin;
      cyc(4);
      chk(observer_active, rows[i].obs);
      chk({observer_gain, observer_filter}, rows[i].obs ? 32'h0011_0044 : 32'h0000_0000);
      chk(inertia_ratio, rows[i].sec ? 16'h0022 : 16'h0033);
    end
    // offsets
    function_expansion_setting = 16'h0006; inertia_select_input = 1'b0; drive_cond = 4'h0;
    cyc(3);
    chk(torque_cmd_out, 16'h0110);
    drive_cond = 4'h8; unbalanced_load_offset = 16'h0020;
    cyc(3);
    chk(torque_cmd_out, 16'h0110);
    req_rev = 1'b1;
    cyc(1);
    req_rev = 1'b0;
    cyc(4);
    chk(torque_cmd_out, 16'h0123);
    dly = 4'h5; req_fwd = 1'b1;
    cyc(1);
    req_fwd = 1'b0;
    cyc(10);
    chk(torque_cmd_out, 16'h0125);
    control_mode = scs_pkg::MODE_TORQUE;
    cyc(3);
    chk(torque_cmd_out, 16'h0100);
    control_mode = scs_pkg::MODE_SPEED; drive_cond = 4'h0;
    cyc(3);
    chk(torque_cmd_out, 16'h0120);
    torque_cmd_in = 16'h0200;
    chk(torque_cmd_out, 16'h0120);
    cyc(1);
    chk(torque_cmd_out, 16'h0220);
    // gain sets
    control_mode = scs_pkg::MODE_POSITION; drive_cond = 4'h8; gain2_condition = 1'b1;
    cyc(2);
    chk(gain_state, scs_pkg::GAIN_SECOND);
    chk({loop_gain, filters_use_second, observer_active}, {32'h0200_0300, 2'b10});
    gain2_condition = 1'b0;
    cyc(1);
    chk(gain_state, scs_pkg::GAIN_THIRD);
    chk({loop_gain, filters_use_second}, {32'h0096_012C, 1'b0});
    chk(gain_ramp_time, 16'h0033);
    n = 1;
    while (gain_state === scs_pkg::GAIN_THIRD && n < 20) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 8 && n <= 10), 32'h0000_0001);
    chk({gain_state, gain_ramp_time}, {scs_pkg::GAIN_FIRST, 16'h0000});
    gain2_condition = 1'b1;
    cyc(2);
    gain2_condition = 1'b0;
    cyc(3);
    gain2_condition = 1'b1;
    cyc(1);
    chk(gain_state, scs_pkg::GAIN_SECOND);
    gain2_condition = 1'b0;
    cyc(2);
    drive_cond = 4'h0;
    cyc(1);
    chk(gain_state, scs_pkg::GAIN_FIRST);
    drive_cond = 4'h8; third_gain_effective_time = 16'h0000; third_gain_ratio = 16'h0000;
    gain2_condition = 1'b1;
    cyc(2);
    gain2_condition = 1'b0;
    cyc(1);
    chk(gain_state, scs_pkg::GAIN_FIRST);
    summarize();
  end
endmodule

`default_nettype wire
